// File: rtl/carry_bit_skip_dp.sv
/*
 Execution datapath for the carry, complement, rotate, memory-bit and compare
 instructions of the 4-bit core. Holds the accumulator, the carry flag, the
 registered write port toward data memory and a small skip sequencer that
 swallows the instruction after a test that hits.
 Assumes the control unit presents one op per executed instruction with
 opValid, that data memory returns the pointed nibble combinationally in
 the same cycle and accepts memWrEn/memWrData on the next edge, and that
 the fetch side keeps presenting instructions while a skip is pending; the
 swallowed instruction still costs its normal fetch time.
*/
`timescale 1ns/100ps
module carry_bit_skip_dp
	import carry_bit_pkg::*;
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// Instruction from the decoder
	input  wire logic                opValid,
	input  wire op_t                 opCode,
	input  wire logic [INDEX_W-1:0]  bitIndex,
	input  wire logic [NIBBLE_W-1:0] immData,
	// Pointed memory nibble
	input  wire logic [NIBBLE_W-1:0] memRdData,
	output logic                     memWrEn,
	output logic      [NIBBLE_W-1:0] memWrData,
	// Architectural state
	output logic      [NIBBLE_W-1:0] accOut,
	output logic                     carryFlag,
	output logic                     skipPending
);
	// Registered state: accumulator, carry flag and the memory write port
	logic [NIBBLE_W-1:0] acc_q;
	logic                carry_q;
	logic                memWrEn_q;
	logic [NIBBLE_W-1:0] memWrData_q;

	// Next values, chosen by the selection wires further down
	wire logic [NIBBLE_W-1:0] acc_d;
	wire logic                carry_d;
	wire logic                memWrEn_d;
	wire logic [NIBBLE_W-1:0] memWrData_d;

	// Skip sequencing: a test that hits moves to the suppress state, and the
	// next presented instruction is swallowed on the way back
	typedef enum logic {
		ST_EXECUTE  = 1'h0,
		ST_SUPPRESS = 1'h1
	} skip_state_t;

	skip_state_t skipState_q;
	skip_state_t skipState_d;

	// Bit lane results for the pointed nibble
	wire logic [NIBBLE_W-1:0] nibbleSet;
	wire logic [NIBBLE_W-1:0] nibbleClr;
	wire logic                memBit;

	// Operations that change state, already gated by execOp
	wire logic skipActive;
	wire logic execOp;
	wire logic doSetCarry;
	wire logic doClrCarry;
	wire logic doCompl;
	wire logic doRotate;
	wire logic doBitSet;
	wire logic doMemWrite;

	// Candidate results, all built from the state before this instruction
	wire logic [NIBBLE_W-1:0] accCompl;
	wire logic [NIBBLE_W-1:0] accRotated;
	wire logic                carryRotated;
	wire logic [NIBBLE_W-1:0] bitEqMem;
	wire logic [NIBBLE_W-1:0] bitEqImm;
	wire logic                accEqMem;
	wire logic                accEqImm;
	wire logic [NIBBLE_W-1:0] memWriteValue;
	wire logic                skipCond;

	// Exact match of the presented op code against one operation
	function automatic logic opIs(input op_t code, input op_t want);
		return code == want;
	endfunction

	// Read-modify-write ops, the only ones that write data memory
	function automatic logic writesMemory(input op_t code);
		return opIs(code, OP_BSET) || opIs(code, OP_BCLR);
	endfunction

	// Skip decision of the four test ops; every other op never skips
	function automatic logic skipTaken(
		input op_t  code,
		input logic carryNow,
		input logic bitNow,
		input logic eqMem,
		input logic eqImm
	);
		case (code)
			OP_TSTC: skipTaken = !carryNow;
			OP_BTST: skipTaken = !bitNow;
			OP_CMPM: skipTaken = eqMem;
			OP_CMPI: skipTaken = eqImm;
			default: skipTaken = 1'h0;
		endcase
	endfunction

	bit_lane_unit i_bit_lane_unit (
		.nibbleIn  (memRdData),
		.bitIndex  (bitIndex),
		.nibbleSet (nibbleSet),
		.nibbleClr (nibbleClr),
		.bitValue  (memBit)
	);

	// An instruction presented while a skip is pending is consumed as a no-op
	assign skipActive = (skipState_q == ST_SUPPRESS);
	assign execOp     = opValid && !skipActive;
	assign doSetCarry = execOp && opIs(opCode, OP_SETC);
	assign doClrCarry = execOp && opIs(opCode, OP_CLRC);
	assign doCompl    = execOp && opIs(opCode, OP_CMPL);
	assign doRotate   = execOp && opIs(opCode, OP_ROTR);
	assign doBitSet   = execOp && opIs(opCode, OP_BSET);
	assign doMemWrite = execOp && writesMemory(opCode);

	assign accCompl     = ~acc_q;
	assign accRotated   = {carry_q, acc_q[MSB_POS:LSB_POS+1]};
	assign carryRotated = acc_q[LSB_POS];

	// Per-bit equality; the compares are a reduction of these lanes
	for (genvar i = 0; i < NIBBLE_W; i++) begin : g_bit_eq
		assign bitEqMem[i] = (acc_q[i] == memRdData[i]);
		assign bitEqImm[i] = (acc_q[i] == immData[i]);
	end

	assign accEqMem = &bitEqMem;
	assign accEqImm = &bitEqImm;

	// Tests read state only; the skip lands on the next presented instruction
	assign skipCond = skipTaken(opCode, carry_q, memBit, accEqMem, accEqImm);

	// Complement or rotate, otherwise the accumulator holds
	assign acc_d = doCompl ? accCompl :
		doRotate ? accRotated :
		acc_q;

	// Only set, clear and rotate write carry; complement leaves it alone
	assign carry_d = doSetCarry ? 1'h1 :
		doClrCarry ? 1'h0 :
		doRotate ? carryRotated :
		carry_q;

	// Data holds its last value between writes so a slow memory strobe still
	// sees a steady word; the enable is a one-cycle pulse
	assign memWriteValue = doBitSet ? nibbleSet : nibbleClr;
	assign memWrEn_d     = doMemWrite;
	assign memWrData_d   = doMemWrite ? memWriteValue : memWrData_q;

	always_comb begin
		skipState_d = skipState_q;
		case (skipState_q)
			ST_EXECUTE: begin
				if (opValid && skipCond) begin
					skipState_d = ST_SUPPRESS;
				end
			end
			ST_SUPPRESS: begin
				// A swallowed test cannot start a new skip, so skips never chain
				if (opValid) begin
					skipState_d = ST_EXECUTE;
				end
			end
			default: skipState_d = ST_EXECUTE;
		endcase
	end

	// One short register per state element; reset is synchronous
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acc_q <= ACC_RESET;
		end else begin
			acc_q <= acc_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			carry_q <= CARRY_RESET;
		end else begin
			carry_q <= carry_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			skipState_q <= ST_EXECUTE;
		end else begin
			skipState_q <= skipState_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			memWrEn_q <= WREN_RESET;
		end else begin
			memWrEn_q <= memWrEn_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			memWrData_q <= WDATA_RESET;
		end else begin
			memWrData_q <= memWrData_d;
		end
	end

	assign accOut      = acc_q;
	assign carryFlag   = carry_q;
	assign skipPending = skipActive;
	assign memWrEn     = memWrEn_q;
	assign memWrData   = memWrData_q;
endmodule

// File: rtl/carry_bit_pkg.sv
/*
 Constants shared by the carry, bit, compare and skip datapath: data widths,
 reset values and the operation codes decoded by the core's control unit.
 Assumes the instruction decoder outside maps each instruction onto one op code.

// What this block does
// - Set carry flag, nothing else changes
// - Clear carry flag, nothing else changes
// - Skip next instruction when carry is zero
// - Accumulator becomes its one's complement
// - Rotate accumulator right through carry flag
// - Set indexed bit of pointed memory nibble
// - Clear indexed bit of pointed memory nibble
// - Skip next when indexed memory bit zero
// - Skip next when accumulator equals memory
// - Skip next when accumulator equals immediate
*/
package carry_bit_pkg;
	localparam int NIBBLE_W = 4;
	localparam int INDEX_W  = 2;
	localparam logic [NIBBLE_W-1:0] ACC_RESET   = 4'h0;
	localparam logic                CARRY_RESET = 1'b0;
	localparam logic                WREN_RESET  = 1'h0;
	localparam logic [NIBBLE_W-1:0] WDATA_RESET = 4'h0;
	localparam int MSB_POS = NIBBLE_W - 1;
	localparam int LSB_POS = 0;

	typedef enum logic [3:0] {
		OP_NONE   = 4'h0,
		OP_SETC   = 4'h1,
		OP_CLRC   = 4'h2,
		OP_TSTC   = 4'h3,
		OP_CMPL   = 4'h4,
		OP_ROTR   = 4'h5,
		OP_BSET   = 4'h6,
		OP_BCLR   = 4'h7,
		OP_BTST   = 4'h8,
		OP_CMPM   = 4'h9,
		OP_CMPI   = 4'ha
	} op_t;
endpackage

// File: rtl/bit_lane_unit.sv
/*
 Combinational nibble helper: sets, clears or picks one bit of a memory nibble.
 Assumes the index is already valid; no storage of its own.
*/
`timescale 1ns/100ps
module bit_lane_unit
	import carry_bit_pkg::*;
(
	// Operand
	input  wire logic [NIBBLE_W-1:0] nibbleIn,
	input  wire logic [INDEX_W-1:0]  bitIndex,
	// Results
	output logic      [NIBBLE_W-1:0] nibbleSet,
	output logic      [NIBBLE_W-1:0] nibbleClr,
	output logic                     bitValue
);
	wire logic [NIBBLE_W-1:0] bitMask;

	assign bitMask   = NIBBLE_W'(1) << bitIndex;
	assign nibbleSet = nibbleIn | bitMask;
	assign nibbleClr = nibbleIn & ~bitMask;
	assign bitValue  = nibbleIn[bitIndex];
endmodule

// File: bench/carry_bit_checker.sv
/* Assertions on the carry, bit and compare datapath ports.
 Assumes binding by name to carry_bit_skip_dp. */
`timescale 1ns/100ps
module carry_bit_checker
	import carry_bit_pkg::*;
(
	// Watched ports
	input wire logic                sys_clk,
	input wire logic                reset,
	input wire logic                opValid,
	input wire op_t                 opCode,
	input wire logic [INDEX_W-1:0]  bitIndex,
	input wire logic [NIBBLE_W-1:0] immData,
	input wire logic [NIBBLE_W-1:0] memRdData,
	input wire logic                memWrEn,
	input wire logic [NIBBLE_W-1:0] memWrData,
	input wire logic [NIBBLE_W-1:0] accOut,
	input wire logic                carryFlag,
	input wire logic                skipPending
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Suppressed ops must not trip the per-op checks
	wire ex = opValid && !skipPending;
	a_set_carry: assert property (ex && opCode == OP_SETC |=> carryFlag &&
		$stable(accOut) && !memWrEn) else $error("set carry");
	a_clear_carry: assert property (ex && opCode == OP_CLRC |=> !carryFlag &&
		$stable(accOut) && !memWrEn) else $error("clear carry");
	a_carry_skip: assert property (ex && opCode == OP_TSTC |=> skipPending != $past(carryFlag))
		else $error("carry skip");
	a_acc_compl: assert property (ex && opCode == OP_CMPL |=> accOut == ~$past(accOut) &&
		$stable(carryFlag)) else $error("complement");
	a_acc_rotate: assert property (ex && opCode == OP_ROTR |=>
		{accOut, carryFlag} == {$past(carryFlag), $past(accOut)}) else $error("rotate");
	a_bit_set: assert property (ex && opCode == OP_BSET |=> memWrEn &&
		memWrData == ($past(memRdData) | 4'h1 << $past(bitIndex))) else $error("bit set");
	a_bit_clear: assert property (ex && opCode == OP_BCLR |=> memWrEn &&
		memWrData == ($past(memRdData) & ~(4'h1 << $past(bitIndex)))) else $error("bit clr");
	a_bit_skip: assert property (ex && opCode == OP_BTST |=>
		skipPending == !$past(memRdData[bitIndex])) else $error("bit skip");
	a_mem_compare: assert property (ex && opCode == OP_CMPM |=>
		skipPending == ($past(accOut) == $past(memRdData))) else $error("mem compare");
	a_imm_compare: assert property (ex && opCode == OP_CMPI |=>
		skipPending == ($past(accOut) == $past(immData))) else $error("imm compare");
	a_skip_quiet: assert property (opValid && skipPending |=> !skipPending && !memWrEn &&
		$stable(accOut) && $stable(carryFlag)) else $error("skip quiet");
	cover property (ex && opCode == OP_BSET);
	cover property (ex && opCode == OP_ROTR);
	cover property (opValid && skipPending);
	cover property (ex && opCode == OP_CMPI ##1 skipPending);
endmodule

// File: bench/carry_bit_skip_dp_tb_top.sv
/* Directed self-checking bench for carry_bit_skip_dp.
 Assumes memory returns the pointed nibble from the bench. */
`timescale 1ns/100ps
module carry_bit_skip_dp_tb_top;
	import carry_bit_pkg::*;
	logic       sys_clk = 0, reset = 1, opValid = 0, memWrEn, carryFlag, skipPending;
	logic [1:0] bitIndex = 0;
	logic [3:0] immData = 0, memRdData = 0, memWrData, accOut;
	op_t        opCode = OP_NONE;
	int         bad_count = 0, checks = 0;
	carry_bit_skip_dp i_carry_bit_skip_dp (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.opValid     (opValid),
		.opCode      (opCode),
		.bitIndex    (bitIndex),
		.immData     (immData),
		.memRdData   (memRdData),
		.memWrEn     (memWrEn),
		.memWrData   (memWrData),
		.accOut      (accOut),
		.carryFlag   (carryFlag),
		.skipPending (skipPending)
	);
	initial forever #20 sys_clk = ~sys_clk;
	task chk(logic [4:0] s, e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	// Idle edge first, so opValid is never lowered and raised in one step
	task op(op_t o, logic [3:0] d, logic [1:0] j);
		@(posedge sys_clk) #1 opValid = 1;
		opCode = o;
		immData = d;
		memRdData = d;
		bitIndex = j;
		@(posedge sys_clk) #1 opValid = 0;
	endtask
	task t_carry;
		op(OP_SETC, 0, 0); chk({carryFlag, accOut}, 5'h10);
		op(OP_TSTC, 0, 0); chk(skipPending, 0);
		op(OP_CLRC, 0, 0); chk({carryFlag, accOut}, 0);
		op(OP_TSTC, 0, 0); chk(skipPending, 1);
		op(OP_SETC, 0, 0); chk({skipPending, carryFlag}, 0);
		$display("carry test done");
	endtask
	task t_acc;
		op(OP_CMPL, 0, 0); chk(accOut, 4'hf);
		op(OP_ROTR, 0, 0); chk({carryFlag, accOut}, 5'h17);
		op(OP_CMPI, 4'h7, 0); chk(skipPending, 1);
		op(OP_CMPL, 0, 0); chk(accOut, 4'h7);
		op(OP_CMPM, 4'h6, 0); chk(skipPending, 0);
		op(OP_CMPM, 4'h7, 0); chk(skipPending, 1);
		op(OP_NONE, 0, 0);
		op(OP_CMPI, 4'h8, 0); chk(skipPending, 0);
		op(OP_CMPL, 0, 0); chk({carryFlag, accOut}, 5'h18);
		$display("acc test done");
	endtask
	task t_bits;
		for (int j = 0; j < 4; j++) begin
			op(OP_BSET, 4'h0, 2'(j)); chk({memWrEn, memWrData}, 5'h10 | 1 << j);
			op(OP_BCLR, 4'hf, 2'(j)); chk({memWrEn, memWrData}, 5'h1f ^ 1 << j);
			op(OP_BTST, 4'h1 << j, 2'(j)); chk({memWrEn, skipPending}, 0);
			op(OP_BTST, 4'hf ^ 4'h1 << j, 2'(j)); chk(skipPending, 1);
			op(OP_NONE, 0, 0);
		end
		$display("bit test done");
	endtask
	task finish_test;
		$display("checks=%0d bad=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 reset = 0;
		t_carry();
		t_acc();
		t_bits();
		finish_test();
	end
endmodule
bind carry_bit_skip_dp carry_bit_checker i_carry_bit_checker (
	.sys_clk     (sys_clk),
	.reset       (reset),
	.opValid     (opValid),
	.opCode      (opCode),
	.bitIndex    (bitIndex),
	.immData     (immData),
	.memRdData   (memRdData),
	.memWrEn     (memWrEn),
	.memWrData   (memWrData),
	.accOut      (accOut),
	.carryFlag   (carryFlag),
	.skipPending (skipPending)
);
